/* cfc_pkg.sv */
// Constants and types for the counter/frequency command handler.
package cfc_pkg;

	// ----------------------------------------
	// Channels, buffers and type codes
	// ----------------------------------------
	localparam int NUM_CH = 8;
	localparam int BUF_LEN = 12;
	localparam int REG_AW = 8;
	localparam logic [7:0] TYPE_UPCNT = 8'h50;
	localparam logic [7:0] TYPE_FREQ = 8'h51;

	// ----------------------------------------
	// Characters on the serial command line
	// ----------------------------------------
	localparam logic [7:0] CH_AT = 8'h40;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_OK = 8'h21;
	localparam logic [7:0] CH_BAD = 8'h3F;
	localparam logic [7:0] CH_F = 8'h46;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_H = 8'h48;
	localparam logic [7:0] CH_T = 8'h54;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic [7:0] CH_C = 8'h43;
	localparam logic [7:0] CH_G = 8'h47;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_7 = 8'h37;

	// ----------------------------------------
	// Register offsets and reset values
	// ----------------------------------------
	localparam logic [REG_AW-1:0] REG_ADDR = 8'h00;
	localparam logic [REG_AW-1:0] REG_STOP = 8'h04;
	localparam logic [REG_AW-1:0] REG_MODES = 8'h08;
	localparam logic [REG_AW-1:0] REG_TYPE0 = 8'h10;
	localparam logic [7:0] ADDR_RST = 8'h01;
	localparam logic [7:0] TYPE_RST = TYPE_UPCNT;
	localparam logic [7:0] TIMEOUT_RST = 8'h0A;
	localparam int MODES_HIGH_LSB = 8;
	localparam int MODES_TMO_LSB = 16;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 40;
	localparam int TENTH_NS = 100_000_000;
	localparam int TENTH_CYC = TENTH_NS / CLK_NS;

	typedef enum logic [1:0] {ST_IDLE, ST_COLLECT, ST_SEND} cfc_st_t;
	typedef enum logic [2:0] {
		ACT_NONE, ACT_AUTO, ACT_HIGH, ACT_TMO, ACT_PRESET
	} cfc_act_t;

endpackage

/* cfc_cmd_handler.sv */
// Command interpreter for frequency-mode and preset configuration.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Auto-frequency write sets each frequency-type channel's mode from the mask bit.
// - Accepted command answers '!' address, any read data, CR; rejected answers '?' address CR.
// - Addresses 00 to FF; every reply echoes our own address.
// - Frequency commands act only on channels of frequency type code.
// - High-frequency read returns '!', address and the enable mask.
// - High-frequency write loads the mask and replies '!' with address.
// - Timeout read returns '!', address and the two timeout digits.
// - Timeout counts in tenths of a second.
// - Timeout write stores the two digits and replies '!' with address.
// - No pulse within a nonzero timeout reports that channel's frequency as zero.
// - Preset read replies '!', address and the channel's preset value.
// - Preset values travel as exactly eight hex digits, 32 bits.
// - Preset write stores eight digits for the channel, replies '!'.
// - Preset commands apply only to up-counter type channels.
// - Stop-on-overflow read returns '!', address and the enable mask.
// - Stop-on-overflow applies only to up-counter type channels.
// - Bad syntax, line error or foreign address gives no reply.
module cfc_cmd_handler #(
	parameter int unsigned P_TENTH_CYC = cfc_pkg::TENTH_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_valid,
	input wire logic i_rx_err,
	output logic [7:0] o_tx_data,
	output logic o_tx_valid,
	input wire logic i_tx_ready,
	input wire logic [cfc_pkg::REG_AW-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	input wire logic [cfc_pkg::NUM_CH-1:0] i_pulse,
	output logic [cfc_pkg::NUM_CH-1:0] o_auto_freq_en,
	output logic [cfc_pkg::NUM_CH-1:0] o_high_freq_en,
	output logic [7:0] o_timeout,
	output logic [cfc_pkg::NUM_CH-1:0] o_freq_zero,
	output logic [cfc_pkg::NUM_CH-1:0] o_stop_at_ovf,
	output logic [32*cfc_pkg::NUM_CH-1:0] o_preset
);
	import cfc_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) begin
			hex_val = {1'b1, c[3:0]};
		end else if ((c >= 8'h41 && c <= 8'h46) ||
				(c >= 8'h61 && c <= 8'h66)) begin
			hex_val = {1'b1, 4'(c[3:0] + 4'h9)};
		end else begin
			hex_val = 5'h00;
		end
	endfunction

	function automatic logic [7:0] hex_chr(input logic [3:0] n);
		hex_chr = (n < 4'hA) ? 8'(CH_0 + {4'h0, n}) : 8'(8'h37 + {4'h0, n});
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	cfc_st_t st_r;
	cfc_act_t dec_act;
	logic [7:0] buf_r [BUF_LEN];
	logic [3:0] len_r;
	logic ovf_r, err_r;
	logic [7:0] addr_r, timeout_r;
	logic [NUM_CH-1:0] stop_r, auto_r, high_r, freq_ch, up_ch;
	logic [7:0] type_r [NUM_CH];
	logic [31:0] preset_r [NUM_CH];
	logic dec_reply, dec_ok, accept, tx_last, tx_fire;
	logic [3:0] dec_nd, rsp_nd_r, idx_r, idx_nxt;
	logic [31:0] dec_data;
	logic [39:0] rsp_sh_r;
	logic [7:0] vv, tx_data_r;
	logic tx_valid_r;
	logic [2:0] dec_ch;
	logic [21:0] pre_r;
	logic tick;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	always_comb begin
		logic [4:0] hh, hl, vh, vl, d;
		logic addr_ok, v_ok, g_ok, data_ok;
		logic [15:0] code;
		d = 5'h00;
		hh = hex_val(buf_r[0]);
		hl = hex_val(buf_r[1]);
		vh = hex_val(buf_r[4]);
		vl = hex_val(buf_r[5]);
		code = {buf_r[2], buf_r[3]};
		addr_ok = len_r >= 4'd2 && hh[4] && hl[4] &&
			{hh[3:0], hl[3:0]} == addr_r;
		v_ok = vh[4] && vl[4];
		vv = {vh[3:0], vl[3:0]};
		g_ok = buf_r[2] == CH_G && buf_r[3] >= CH_0 && buf_r[3] <= CH_7;
		dec_ch = buf_r[3][2:0];
		dec_data = 32'h0000_0000;
		data_ok = 1'b1;
		for (int i = 0; i < 8; i++) begin
			d = hex_val(buf_r[4+i]);
			data_ok = data_ok & d[4];
			dec_data = {dec_data[27:0], d[3:0]};
		end
		dec_reply = 1'b0;
		dec_ok = 1'b1;
		dec_nd = 4'd0;
		dec_act = ACT_NONE;
		if (code == {CH_F, CH_A} && len_r == 4'd6 && v_ok) begin
			dec_reply = 1'b1;
			dec_ok = |freq_ch;
			dec_act = ACT_AUTO;
		end else if (code == {CH_F, CH_H} && len_r == 4'd4) begin
			dec_reply = 1'b1;
			dec_ok = |freq_ch;
			dec_nd = 4'd2;
			dec_data = {high_r, 24'h00_0000};
		end else if (code == {CH_F, CH_H} && len_r == 4'd6 && v_ok) begin
			dec_reply = 1'b1;
			dec_ok = |freq_ch;
			dec_act = ACT_HIGH;
		end else if (code == {CH_F, CH_T} && len_r == 4'd4) begin
			dec_reply = 1'b1;
			dec_ok = |freq_ch;
			dec_nd = 4'd2;
			dec_data = {timeout_r, 24'h00_0000};
		end else if (code == {CH_F, CH_T} && len_r == 4'd6 && v_ok) begin
			dec_reply = 1'b1;
			dec_ok = |freq_ch;
			dec_act = ACT_TMO;
		end else if (code == {CH_S, CH_C} && len_r == 4'd4) begin
			dec_reply = 1'b1;
			dec_ok = |up_ch;
			dec_nd = 4'd2;
			dec_data = {stop_r & up_ch, 24'h00_0000};
		end else if (g_ok && len_r == 4'd4) begin
			dec_reply = 1'b1;
			dec_ok = up_ch[dec_ch];
			dec_nd = 4'd8;
			dec_data = preset_r[dec_ch];
		end else if (g_ok && len_r == 4'd12 && data_ok) begin
			dec_reply = 1'b1;
			dec_ok = up_ch[dec_ch];
			dec_act = ACT_PRESET;
		end
		if (!dec_ok) begin
			dec_nd = 4'd0;
			dec_act = ACT_NONE;
		end
		if (!addr_ok) begin
			dec_reply = 1'b0;
		end
	end

	// A command ends at CR; anything marred on the way is dropped silently.
	assign accept = st_r == ST_COLLECT && i_rx_valid && i_rx_data == CH_CR &&
		!err_r && !i_rx_err && !ovf_r && dec_reply;

	// ----------------------------------------
	// Receive parser
	// ----------------------------------------
	// Bytes arriving while a reply is being sent are ignored: the line is
	// shared and half duplex, so nothing valid can come then.
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			st_r <= ST_IDLE;
			len_r <= 4'd0;
			ovf_r <= 1'b0;
			err_r <= 1'b0;
			for (int i = 0; i < BUF_LEN; i++) begin
				buf_r[i] <= 8'h00;
			end
		end else begin
			unique case (st_r)
				ST_IDLE: begin
					if (i_rx_valid && i_rx_data == CH_AT) begin
						st_r <= ST_COLLECT;
						len_r <= 4'd0;
						ovf_r <= 1'b0;
						// A line error on the opening mark spoils the command too.
						err_r <= i_rx_err;
					end
				end
				ST_COLLECT: begin
					if (i_rx_err) begin
						err_r <= 1'b1;
					end
					if (i_rx_valid) begin
						if (i_rx_data == CH_AT) begin
							len_r <= 4'd0;
							ovf_r <= 1'b0;
							err_r <= i_rx_err;
						end else if (i_rx_data == CH_CR) begin
							st_r <= accept ? ST_SEND : ST_IDLE;
						end else if (len_r < 4'(BUF_LEN)) begin
							buf_r[len_r] <= i_rx_data;
							len_r <= 4'(len_r + 4'd1);
						end else begin
							ovf_r <= 1'b1;
						end
					end
				end
				ST_SEND: begin
					if (tx_last) begin
						st_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Reply transmitter
	// ----------------------------------------
	assign tx_fire = tx_valid_r && i_tx_ready;
	assign idx_nxt = 4'(idx_r + 4'd1);
	assign tx_last = tx_fire && idx_r == 4'(rsp_nd_r + 4'd3);

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			tx_valid_r <= 1'b0;
			tx_data_r <= 8'h00;
			idx_r <= 4'd0;
			rsp_nd_r <= 4'd0;
			rsp_sh_r <= 40'h00_0000_0000;
		end else if (accept) begin
			tx_valid_r <= 1'b1;
			tx_data_r <= dec_ok ? CH_OK : CH_BAD;
			idx_r <= 4'd0;
			rsp_nd_r <= dec_nd;
			rsp_sh_r <= {addr_r, dec_data};
		end else if (tx_fire) begin
			idx_r <= idx_nxt;
			if (tx_last) begin
				tx_valid_r <= 1'b0;
			end else if (idx_nxt <= 4'(rsp_nd_r + 4'd2)) begin
				tx_data_r <= hex_chr(rsp_sh_r[39:36]);
				rsp_sh_r <= {rsp_sh_r[35:0], 4'h0};
			end else begin
				tx_data_r <= CH_CR;
			end
		end
	end

	assign o_tx_data = tx_data_r;
	assign o_tx_valid = tx_valid_r;

	// ----------------------------------------
	// Settings written by commands
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			auto_r <= '0;
			high_r <= '0;
			timeout_r <= TIMEOUT_RST;
			for (int i = 0; i < NUM_CH; i++) begin
				preset_r[i] <= 32'h0000_0000;
			end
		end else if (accept) begin
			unique case (dec_act)
				ACT_AUTO: auto_r <= (auto_r & ~freq_ch) | (vv & freq_ch);
				ACT_HIGH: high_r <= (high_r & ~freq_ch) | (vv & freq_ch);
				ACT_TMO: timeout_r <= vv;
				ACT_PRESET: preset_r[dec_ch] <= dec_data;
				ACT_NONE: ;
			endcase
		end
	end

	assign o_auto_freq_en = auto_r;
	assign o_high_freq_en = high_r;
	assign o_timeout = timeout_r;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			addr_r <= ADDR_RST;
			stop_r <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				type_r[i] <= TYPE_RST;
			end
		end else if (i_reg_wr) begin
			if (i_reg_addr == REG_ADDR) begin
				addr_r <= i_reg_wdata[7:0];
			end
			if (i_reg_addr == REG_STOP) begin
				stop_r <= i_reg_wdata[NUM_CH-1:0];
			end
			for (int i = 0; i < NUM_CH; i++) begin
				if (i_reg_addr == 8'(REG_TYPE0 + 4 * i)) begin
					type_r[i] <= i_reg_wdata[7:0];
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 32'h0000_0000;
		end else if (i_reg_rd) begin
			o_reg_rdata <= 32'h0000_0000;
			if (i_reg_addr == REG_ADDR) begin
				o_reg_rdata <= {24'h00_0000, addr_r};
			end
			if (i_reg_addr == REG_STOP) begin
				o_reg_rdata <= {24'h00_0000, stop_r};
			end
			if (i_reg_addr == REG_MODES) begin
				o_reg_rdata <= {8'h00, timeout_r, high_r, auto_r};
			end
			for (int i = 0; i < NUM_CH; i++) begin
				if (i_reg_addr == 8'(REG_TYPE0 + 4 * i)) begin
					o_reg_rdata <= {24'h00_0000, type_r[i]};
				end
			end
		end
	end

	// ----------------------------------------
	// Per-channel timing and overflow control
	// ----------------------------------------
	assign tick = pre_r == 22'(P_TENTH_CYC - 1);

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			pre_r <= 22'h00_0000;
		end else begin
			pre_r <= tick ? 22'h00_0000 : 22'(pre_r + 22'd1);
		end
	end

	generate
		for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
			logic sync1_r, sync2_r, prev_r;
			logic [7:0] tenths_r;
			logic zero_r, hold_r;
			assign freq_ch[n] = type_r[n] == TYPE_FREQ;
			assign up_ch[n] = type_r[n] == TYPE_UPCNT;
			always_ff @(posedge i_clk_sys) begin
				if (!i_rst_n) begin
					sync1_r <= 1'b0;
					sync2_r <= 1'b0;
					prev_r <= 1'b0;
				end else begin
					sync1_r <= i_pulse[n];
					sync2_r <= sync1_r;
					prev_r <= sync2_r;
				end
			end
			// The elapsed count saturates, so a dead input stays reported.
			always_ff @(posedge i_clk_sys) begin
				if (!i_rst_n) begin
					tenths_r <= 8'h00;
				end else if (sync2_r && !prev_r) begin
					tenths_r <= 8'h00;
				end else if (tick && tenths_r != 8'hFF) begin
					tenths_r <= 8'(tenths_r + 8'd1);
				end
			end
			always_ff @(posedge i_clk_sys) begin
				if (!i_rst_n) begin
					zero_r <= 1'b0;
					hold_r <= 1'b0;
				end else begin
					zero_r <= freq_ch[n] && timeout_r != 8'h00 &&
						tenths_r >= timeout_r;
					hold_r <= stop_r[n] && up_ch[n];
				end
			end
			assign o_freq_zero[n] = zero_r;
			assign o_stop_at_ovf[n] = hold_r;
			assign o_preset[32*n +: 32] = preset_r[n];
		end
	endgenerate

endmodule // cfc_cmd_handler

`default_nettype wire

/* cfc_props.sv */
// Port assertions for the counter/frequency command handler.
`timescale 1ns/1ns
`default_nettype none
module cfc_props (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic [7:0] o_tx_data,
	input wire logic o_tx_valid,
	input wire logic i_tx_ready,
	input wire logic [cfc_pkg::REG_AW-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [31:0] o_reg_rdata,
	input wire logic [cfc_pkg::NUM_CH-1:0] i_pulse,
	input wire logic [cfc_pkg::NUM_CH-1:0] o_auto_freq_en,
	input wire logic [cfc_pkg::NUM_CH-1:0] o_high_freq_en,
	input wire logic [7:0] o_timeout,
	input wire logic [cfc_pkg::NUM_CH-1:0] o_freq_zero,
	input wire logic [cfc_pkg::NUM_CH-1:0] o_stop_at_ovf
);
	import cfc_pkg::*;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	reply_lead_a: assert property (
		$rose(o_tx_valid) |-> o_tx_data == CH_OK || o_tx_data == CH_BAD)
		else $error("reply does not open with a status mark");
	tx_hold_a: assert property (
		o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
		else $error("reply character lost while stalled");
	tx_drop_a: assert property (
		o_tx_valid && i_tx_ready && o_tx_data == CH_CR |=> !o_tx_valid)
		else $error("reply runs past its end mark");
	rd_unmapped_a: assert property (
		i_reg_rd && i_reg_addr == 8'h0C |=> o_reg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	modes_rd_a: assert property (
		i_reg_rd && i_reg_addr == REG_MODES |=> o_reg_rdata ==
		{8'h00, $past(o_timeout), $past(o_high_freq_en), $past(o_auto_freq_en)})
		else $error("mode read data wrong");
	stop_mask_a: assert property (
		i_reg_wr && i_reg_addr == REG_STOP |-> ##2
		(o_stop_at_ovf & ~$past(i_reg_wdata[7:0], 2)) == 8'h00)
		else $error("overflow stop set on a cleared channel");
	rst_val_a: assert property (disable iff (1'b0)
		!i_rst_n |=> !o_tx_valid && o_timeout == TIMEOUT_RST)
		else $error("reset values wrong");
	zero_clear_a: assert property (
		$rose(i_pulse[1]) |-> ##[1:8] !o_freq_zero[1])
		else $error("zero report not cleared by a pulse");
	// Covers show the awkward paths were reached, not just the plain ones.
	bad_cv: cover property ($rose(o_tx_valid) && o_tx_data == CH_BAD);
	stall_cv: cover property (o_tx_valid && !i_tx_ready);
	zero_cv: cover property ($rose(o_freq_zero[1]));
endmodule // cfc_props
`default_nettype wire

/* cfc_host.sv */
// Host model on the serial command line.
`timescale 1ns/1ns
`default_nettype none
module cfc_host (
	input wire logic i_clk_sys,
	input wire logic i_slow,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	output logic o_rx_err,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready
);
	initial begin
		o_rx_data = 8'h00;
		o_rx_valid = 1'b0;
		o_rx_err = 1'b0;
		o_tx_ready = 1'b0;
	end
	task automatic put(input logic [7:0] c, input logic e);
		@(posedge i_clk_sys);
		o_rx_data <= c;
		o_rx_valid <= 1'b1;
		o_rx_err <= e;
	endtask
	// Sends '@', text and CR, then gathers the reply (0 when none comes).
	task automatic xfer(input string cmd, input logic e,
		output logic [95:0] rep);
		int idle;
		put(8'h40, 1'b0);
		foreach (cmd[i]) put(cmd[i], e);
		put(8'h0D, 1'b0);
		@(posedge i_clk_sys);
		o_rx_valid <= 1'b0;
		o_rx_err <= 1'b0;
		// Idle line must not keep showing the last character.
		o_rx_data <= ~o_rx_data;
		o_tx_ready <= 1'b1;
		rep = '0;
		idle = 0;
		while (idle < 40) begin
			@(posedge i_clk_sys);
			if (i_tx_valid && o_tx_ready) begin
				idle = 0;
				if (i_tx_data == 8'h0D) break;
				rep = {rep[87:0], i_tx_data};
			end else begin
				idle++;
			end
			o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
		end
		o_tx_ready <= 1'b0;
	endtask
endmodule // cfc_host
`default_nettype wire

/* tb.sv */
// Testbench for the counter/frequency command handler.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import cfc_pkg::*;
	logic i_clk_sys, i_rst_n, reg_wr, reg_rd, rx_valid, rx_err, tx_valid;
	logic tx_ready, slow;
	logic [7:0] reg_addr, rx_data, tx_data, tmo, pulse, auto_en, high_en;
	logic [7:0] fzero, stop;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [255:0] preset;
	int mismatches, n_tests;
	cfc_cmd_handler #(.P_TENTH_CYC(10)) dut_u (.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n), .i_rx_data(rx_data), .i_rx_valid(rx_valid),
		.i_rx_err(rx_err), .o_tx_data(tx_data), .o_tx_valid(tx_valid),
		.i_tx_ready(tx_ready), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
		.i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
		.i_pulse(pulse), .o_auto_freq_en(auto_en), .o_high_freq_en(high_en),
		.o_timeout(tmo), .o_freq_zero(fzero), .o_stop_at_ovf(stop),
		.o_preset(preset));
	cfc_host host_u (.i_clk_sys(i_clk_sys), .i_slow(slow),
		.o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_rx_err(rx_err),
		.i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready));
	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end
	task automatic chk(input string what, input logic [95:0] exp,
		input logic [95:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge i_clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge i_clk_sys);
		reg_rd <= 1'b0;
		@(posedge i_clk_sys);
		v = reg_rdata;
	endtask
	task automatic cmd(input string c, input logic e, input logic [95:0] exp);
		logic [95:0] rep;
		host_u.xfer(c, e, rep);
		chk({"reply ", c}, exp, rep);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		mismatches++;
		report_and_stop();
	end
	initial begin
		{reg_wr, reg_rd, slow, reg_addr, reg_wdata, pulse} = '0;
		mismatches = 0;
		n_tests = 0;
		i_rst_n = 1'b0;
		repeat (3) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		rd(REG_ADDR, d);
		chk("address", ADDR_RST, d);
		rd(REG_MODES, d);
		chk("modes", {8'h00, TIMEOUT_RST, 16'h0000}, d);
		rd(8'h0C, d);
		chk("unmapped", 0, d);
		wr(REG_TYPE0 + 8'h04, TYPE_FREQ);
		wr(REG_TYPE0 + 8'h0C, TYPE_FREQ);
		cmd("01FA3A", 1'b0, "!01");
		rd(REG_MODES, d);
		chk("auto mask", 32'h000A_000A, d);
		chk("auto output", 8'h0A, auto_en);
		cmd("01FHff", 1'b0, "!01");
		chk("high output", 8'h0A, high_en);
		cmd("01FH", 1'b0, "!010A");
		slow <= 1'b1;
		cmd("01FT05", 1'b0, "!01");
		chk("timeout output", 8'h05, tmo);
		cmd("01FT", 1'b0, "!0105");
		slow <= 1'b0;
		cmd("01G2F0000000", 1'b0, "!01");
		cmd("01G2", 1'b0, "!01F0000000");
		chk("preset", 32'hF000_0000, preset[95:64]);
		cmd("01G1", 1'b0, "?01");
		wr(REG_STOP, 32'h0000_000F);
		rd(REG_STOP, d);
		chk("stop mask", 32'h0000_000F, d);
		chk("stop output", 8'h05, stop);
		cmd("01SC", 1'b0, "!0105");
		cmd("02FT", 1'b0, 0);
		cmd("01FT", 1'b1, 0);
		cmd("01FX", 1'b0, 0);
		cmd("01G2F00000000", 1'b0, 0);
		chk("preset kept", 32'hF000_0000, preset[95:64]);
		cmd("7@01FT", 1'b0, "!0105");
		wr(REG_ADDR, 32'h0000_00A5);
		cmd("A5FT", 1'b0, "!A505");
		repeat (150) @(posedge i_clk_sys);
		chk("zero report", 8'h0A, fzero);
		pulse <= 8'h02;
		repeat (3) @(posedge i_clk_sys);
		pulse <= 8'h00;
		repeat (8) @(posedge i_clk_sys);
		chk("zero report", 8'h08, fzero);
		report_and_stop();
	end
endmodule // tb
bind cfc_cmd_handler cfc_props props_u (.i_clk_sys(i_clk_sys),
	.i_rst_n(i_rst_n), .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid),
	.i_tx_ready(i_tx_ready), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .i_pulse(i_pulse),
	.o_auto_freq_en(o_auto_freq_en), .o_high_freq_en(o_high_freq_en),
	.o_timeout(o_timeout), .o_freq_zero(o_freq_zero),
	.o_stop_at_ovf(o_stop_at_ovf));
`default_nettype wire
